// ===== logic/rip_i2c_slave.sv
// Two-wire slave port giving a bus master access to the regulator registers.
// Assumes open-drain pins resolved outside; scl and sda arrive asynchronously.
// Behaviour
// - Idle high; start and stop edges detected.
// - One bit per clock, sampled on rise.
// - Repeated start treated like a start.
// - Ignore clock after stop or mismatch.
// - Acknowledge by driving data low.
// - Not-acknowledge by releasing data line.
// - Four selectable addresses, acknowledge own only.
// - Never hold the clock line low.
// - General call is not acknowledged.
// - Keep up with every supported rate.
// - Low-speed filters at reset, and at stop unless hold bit set.
// - Repeated start keeps filter selection.
// - Write: address, pointer, data, all acknowledged.
// - Data loads at acknowledge clock rise.
// - Master code gets nack, selects high speed.
// - Read: pointer write, restart, bytes shifted out.
// - Hold bit keeps high speed across stop.
// - Sequential writes acknowledged and stored.
`timescale 1ns/1ps
`default_nettype none
module rip_i2c_slave
	import rip_pkg::*;
#(
	parameter int DEPTH = 256
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Bus pins
	input wire logic scl_in,
	output logic scl_out,
	output logic scl_oe,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	// Configuration
	input wire logic [1:0] addr_sel,
	// Register contents and status
	output logic [DEPTH*8-1:0] regs_flat,
	output logic hs_mode,
	output logic fast_mode_hold_enable
);
	initial begin
		if (DEPTH < 1 || DEPTH > 256)
			$error("Register depth out of range.");
	end
	////////////////////////////////////////////////////////////////////////////
	// Line conditioning.
	rip_line_if scl_l ();
	rip_line_if sda_l ();
	logic hs_r;
	logic hs_nxt;
	logic hold_r;
	logic hold_nxt;
	rip_line_filter u_scl_filt (
		.sys_clk(sys_clk),
		.rst(rst),
		.pin_in(scl_in),
		.hs_sel(hs_r),
		.line(scl_l)
	);
	rip_line_filter u_sda_filt (
		.sys_clk(sys_clk),
		.rst(rst),
		.pin_in(sda_in),
		.hs_sel(hs_r),
		.line(sda_l)
	);
	logic start_det;
	logic stop_det;
	assign start_det = sda_l.fall & scl_l.level;
	assign stop_det = sda_l.rise & scl_l.level;
	////////////////////////////////////////////////////////////////////////////
	// Protocol state.
	rip_state_e state_r;
	rip_state_e state_nxt;
	logic [3:0] bit_r;
	logic [3:0] bit_nxt;
	logic [7:0] shift_r;
	logic [7:0] shift_nxt;
	logic [7:0] ptr_r;
	logic [7:0] ptr_nxt;
	logic ptr_ok_r;
	logic ptr_ok_nxt;
	logic ack_r;
	logic ack_nxt;
	logic drive_r;
	logic drive_nxt;
	logic mack_r;
	logic mack_nxt;
	logic wr_en;
	logic [7:0] rd_data;
	logic [6:0] own_addr;
	logic [7:0] byte_in;
	always_comb begin
		case (addr_sel)
			2'h0: own_addr = SLAVE_ADDR_0;
			2'h1: own_addr = SLAVE_ADDR_1;
			2'h2: own_addr = SLAVE_ADDR_2;
			default: own_addr = SLAVE_ADDR_3;
		endcase
	end
	assign byte_in = {shift_r[6:0], sda_l.level};
	always_comb begin
		state_nxt = state_r;
		bit_nxt = bit_r;
		shift_nxt = shift_r;
		ptr_nxt = ptr_r;
		ptr_ok_nxt = ptr_ok_r;
		ack_nxt = ack_r;
		drive_nxt = drive_r;
		mack_nxt = mack_r;
		hs_nxt = hs_r;
		hold_nxt = hold_r;
		wr_en = 1'b0;
		if (start_det) begin
			state_nxt = RIP_ADDR;
			bit_nxt = 4'h0;
			drive_nxt = 1'b0;
		end else if (stop_det) begin
			state_nxt = RIP_IDLE;
			drive_nxt = 1'b0;
			hs_nxt = hold_r;
		end else if (state_r != RIP_IDLE && scl_l.rise) begin
			// Data sampled on the rising clock edge.
			case (state_r)
				RIP_ADDR, RIP_RX: begin
					shift_nxt = byte_in;
					bit_nxt = bit_r + 4'h1;
					if (bit_r == BIT_COUNT_LAST) begin
						bit_nxt = 4'h0;
						if (state_r == RIP_ADDR) begin
							state_nxt = RIP_ADDR_ACK;
							ack_nxt = (byte_in[7:1] == own_addr);
							if (byte_in == GENERAL_CALL)
								ack_nxt = 1'b0;
							if (byte_in[7:3] == MASTER_CODE_TOP && !byte_in[0]) begin
								ack_nxt = 1'b0;
								hs_nxt = 1'b1;
							end
						end else begin
							state_nxt = RIP_RX_ACK;
							ack_nxt = 1'b1;
						end
					end
				end
				RIP_ADDR_ACK: begin
					if (!ack_r) begin
						state_nxt = RIP_IDLE;
					end else if (shift_r[0]) begin
						state_nxt = RIP_TX;
					end else begin
						state_nxt = RIP_RX;
						ptr_ok_nxt = 1'b0;
					end
				end
				RIP_RX_ACK: begin
					state_nxt = RIP_RX;
					if (!ptr_ok_r) begin
						ptr_nxt = shift_r;
						ptr_ok_nxt = 1'b1;
					end else begin
						wr_en = 1'b1;
						ptr_nxt = ptr_r + 8'h01;
						if (ptr_r == HOLD_REG_ADDR && !hs_r)
							hold_nxt = shift_r[HOLD_BIT_POS];
					end
				end
				RIP_TX: begin
					bit_nxt = bit_r + 4'h1;
					if (bit_r == BIT_COUNT_LAST) begin
						bit_nxt = 4'h0;
						state_nxt = RIP_TX_ACK;
						ptr_nxt = ptr_r + 8'h01;
					end
				end
				RIP_TX_ACK: begin
					mack_nxt = ~sda_l.level;
					state_nxt = sda_l.level ? RIP_IDLE : RIP_TX;
				end
				default: state_nxt = RIP_IDLE;
			endcase
		end else if (state_r != RIP_IDLE && scl_l.fall) begin
			// Data line changes only while the clock is low.
			case (state_r)
				RIP_ADDR_ACK, RIP_RX_ACK: drive_nxt = ack_r;
				RIP_TX: drive_nxt = ~rd_data[3'(7 - int'(bit_r))];
				default: drive_nxt = 1'b0;
			endcase
			if (state_r == RIP_TX && bit_r == 4'h0)
				drive_nxt = ~rd_data[7];
		end
	end
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state_r <= RIP_IDLE;
			bit_r <= 4'h0;
			shift_r <= 8'h00;
			ptr_r <= 8'h00;
			ptr_ok_r <= 1'b0;
			ack_r <= 1'b0;
			drive_r <= 1'b0;
			mack_r <= 1'b0;
			hs_r <= 1'b0;
			hold_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			bit_r <= bit_nxt;
			shift_r <= shift_nxt;
			ptr_r <= ptr_nxt;
			ptr_ok_r <= ptr_ok_nxt;
			ack_r <= ack_nxt;
			drive_r <= drive_nxt;
			mack_r <= mack_nxt;
			hs_r <= hs_nxt;
			hold_r <= hold_nxt;
		end
	end
	////////////////////////////////////////////////////////////////////////////
	// Register bank.
	rip_reg_bank #(
		.DEPTH(DEPTH)
	) u_regs (
		.sys_clk(sys_clk),
		.rst(rst),
		.wr_en(wr_en),
		.addr(ptr_r),
		.wr_data(shift_r),
		.rd_data(rd_data),
		.regs_flat(regs_flat)
	);
	////////////////////////////////////////////////////////////////////////////
	// Pin drive.
	assign scl_out = 1'b0;
	assign scl_oe = 1'b0;
	assign sda_out = 1'b0;
	assign sda_oe = drive_r;
	assign hs_mode = hs_r;
	assign fast_mode_hold_enable = hold_r;
endmodule
`default_nettype wire

// ===== logic/rip_line_filter.sv
// Synchroniser and glitch filter for one bus line, with edge pulses.
// Assumes an asynchronous pin input and a filter select from sys_clk logic.
`timescale 1ns/1ps
`default_nettype none
module rip_line_filter
	import rip_pkg::*;
#(
	parameter int LS_CYC = LS_FILTER_CYCLES,
	parameter int HS_CYC = HS_FILTER_CYCLES
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Line
	input wire logic pin_in,
	input wire logic hs_sel,
	rip_line_if.src line
);
	initial begin
		if (LS_CYC < 1 || LS_CYC > 15 || HS_CYC < 1 || HS_CYC > LS_CYC)
			$error("Filter lengths out of range.");
	end
	logic [1:0] sync_r;
	logic [1:0] sync_nxt;
	logic [3:0] cnt_r;
	logic [3:0] cnt_nxt;
	logic level_r;
	logic level_nxt;
	logic [3:0] lim;
	always_comb begin
		sync_nxt = {sync_r[0], pin_in};
		lim = hs_sel ? 4'(HS_CYC) : 4'(LS_CYC);
		level_nxt = level_r;
		cnt_nxt = 4'h0;
		if (sync_r[1] != level_r) begin
			cnt_nxt = cnt_r + 4'h1;
			if (cnt_nxt >= lim) begin
				level_nxt = sync_r[1];
				cnt_nxt = 4'h0;
			end
		end
	end
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			sync_r <= 2'h3;
			cnt_r <= 4'h0;
			level_r <= 1'b1;
		end else begin
			sync_r <= sync_nxt;
			cnt_r <= cnt_nxt;
			level_r <= level_nxt;
		end
	end
	assign line.level = level_r;
	assign line.rise = level_nxt & ~level_r;
	assign line.fall = ~level_nxt & level_r;
endmodule
`default_nettype wire

// ===== logic/rip_line_if.sv
// Interface carrying one filtered bus line with its edge pulses.
// Assumes the producer and consumer share sys_clk.
`timescale 1ns/1ps
`default_nettype none
interface rip_line_if;
	logic level;
	logic rise;
	logic fall;
	modport src (output level, output rise, output fall);
	modport dst (input level, input rise, input fall);
endinterface
`default_nettype wire

// ===== logic/rip_pkg.sv
// Constants for the regulator serial slave port.
// Assumes a 40 MHz system clock sampling slow open-drain bus lines.
package rip_pkg;
	localparam int SYS_CLK_HZ = 40000000;
	localparam int ADDR_W = 7;
	localparam int DATA_W = 8;
	localparam logic [6:0] SLAVE_ADDR_0 = 7'h66;
	localparam logic [6:0] SLAVE_ADDR_1 = 7'h67;
	localparam logic [6:0] SLAVE_ADDR_2 = 7'h6e;
	localparam logic [6:0] SLAVE_ADDR_3 = 7'h6f;
	localparam logic [7:0] GENERAL_CALL = 8'h00;
	localparam logic [4:0] MASTER_CODE_TOP = 5'h01;
	localparam logic [3:0] BIT_COUNT_LAST = 4'h7;
	localparam logic [7:0] HOLD_REG_ADDR = 8'h14;
	localparam int HOLD_BIT_POS = 0;
	localparam int LS_FILTER_CYCLES = 8;
	localparam int HS_FILTER_CYCLES = 2;
	typedef enum logic [2:0] {
		RIP_IDLE,
		RIP_ADDR,
		RIP_ADDR_ACK,
		RIP_RX,
		RIP_RX_ACK,
		RIP_TX,
		RIP_TX_ACK
	} rip_state_e;
endpackage

// ===== logic/rip_reg_bank.sv
// Bank of 8-bit control registers written and read by the serial port.
// Assumes one write pulse per byte from the port logic.
`timescale 1ns/1ps
`default_nettype none
module rip_reg_bank
	import rip_pkg::*;
#(
	parameter int DEPTH = 256
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Access
	input wire logic wr_en,
	input wire logic [7:0] addr,
	input wire logic [7:0] wr_data,
	output logic [7:0] rd_data,
	output logic [DEPTH*8-1:0] regs_flat
);
	initial begin
		if (DEPTH < 1 || DEPTH > 256)
			$error("Register depth out of range.");
	end
	logic [7:0] mem_r [DEPTH];
	logic [7:0] mem_nxt [DEPTH];
	always_comb begin
		for (int i = 0; i < DEPTH; i++) begin
			mem_nxt[i] = mem_r[i];
		end
		if (wr_en && int'(addr) < DEPTH)
			mem_nxt[addr] = wr_data;
	end
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_r[i] <= 8'h00;
			end
		end else begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_r[i] <= mem_nxt[i];
			end
		end
	end
	assign rd_data = (int'(addr) < DEPTH) ? mem_r[addr] : 8'h00;
	genvar g;
	generate
		for (g = 0; g < DEPTH; g++) begin : g_flat
			assign regs_flat[g*8 +: 8] = mem_r[g];
		end
	endgenerate
endmodule
`default_nettype wire

// ===== sim/rip_i2c_assertions.sv
// Checker of the slave port pins and status outputs.
// Assumes a bind onto rip_i2c_slave.
`timescale 1ns/1ps
`default_nettype none
module rip_i2c_assertions #(
	parameter int DEPTH = 256
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Pins and status
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic scl_oe,
	input wire logic sda_oe,
	input wire logic scl_out,
	input wire logic sda_out,
	input wire logic [DEPTH*8-1:0] regs_flat,
	input wire logic hs_mode,
	input wire logic fast_mode_hold_enable
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);
	a_no_stretch: assert property (!scl_oe)
		else $error("clock held");
	a_pins_low: assert property (!sda_out && !scl_out)
		else $error("pin drives high");
	a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_in)
		else $error("data moved in clock high");
	a_reset_idle: assert property ($fell(rst)
		|-> !(hs_mode || sda_oe || fast_mode_hold_enable)) else $error("not idle");
	a_stop_slow: assert property (scl_in && $rose(sda_in) && !fast_mode_hold_enable
		|-> ##[1:20] !hs_mode) else $error("fast filters kept");
	a_restart_keeps: assert property (scl_in && $fell(sda_in) |=> $stable(hs_mode)[*8])
		else $error("start moved filters");
	a_hold_keeps: assert property (scl_in && $rose(sda_in) && fast_mode_hold_enable
		&& hs_mode |=> hs_mode[*8]) else $error("hold lost");
	a_hold_in_slow: assert property ($changed(fast_mode_hold_enable) |-> !$past(hs_mode))
		else $error("hold set when fast");
	a_load_scl_high: assert property ($changed(regs_flat) |-> scl_in)
		else $error("load off clock high");
	c_ack: cover property ($rose(sda_oe));
	c_hs: cover property ($rose(hs_mode));
	c_hold: cover property ($rose(fast_mode_hold_enable));
endmodule
bind rip_i2c_slave rip_i2c_assertions #(.DEPTH(DEPTH)) chk_i (.*);
`default_nettype wire

// ===== sim/rip_mstr.sv
// Bus master model on the two open-drain lines.
// Assumes pull-ups resolve the lines in the bench.
`timescale 1ns/1ps
`default_nettype none
module rip_mstr (
	// Clock
	input wire logic sys_clk,
	// Lines, high pulls low
	input wire logic sda_in,
	output var logic scl_lo = 1'b0,
	output var logic sda_lo = 1'b0
);
	int qtr = 10;
	task automatic drv(input logic c, input logic d);
		scl_lo <= c;
		sda_lo <= d;
		repeat (qtr) @(posedge sys_clk);
	endtask
	task automatic start;
		drv(scl_lo, 1'b0);
		drv(1'b0, 1'b0);
		drv(1'b0, 1'b1);
		drv(1'b1, 1'b1);
	endtask
	task automatic stop;
		drv(1'b1, 1'b1);
		drv(1'b0, 1'b1);
		drv(1'b0, 1'b0);
	endtask
	task automatic bit_io(input logic v, output logic s);
		drv(1'b1, !v);
		drv(1'b0, !v);
		s = sda_in;
		drv(1'b0, !v);
		drv(1'b1, !v);
	endtask
	task automatic xfer(input logic [8:0] o, output logic [8:0] r);
		for (int i = 8; i >= 0; i--)
			bit_io(o[i], r[i]);
	endtask
endmodule
`default_nettype wire

// ===== sim/testbench.sv
// Self-checking bench for the serial slave port.
// Assumes the master model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic [1:0] addr_sel = 2'h0;
	logic scl_lo, sda_lo, scl_out, scl_oe, sda_out, sda_oe, hs_mode, fast_mode_hold_enable;
	logic [2047:0] regs_flat;
	int bad_count = 0;
	int comparisons = 0;
	wire scl_in = !(scl_lo || (scl_oe && !scl_out));
	wire sda_in = !(sda_lo || (sda_oe && !sda_out));
	rip_i2c_slave #(.DEPTH(256)) rip_i2c_slave_i (.*);
	rip_mstr rip_mstr_i (.*);
	always #12.5 sys_clk = !sys_clk;
	task automatic end_sim;
		if (bad_count == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input logic [8:0] got, input logic [8:0] exp);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic xb(input logic [8:0] o, input logic [8:0] e);
		logic [8:0] r;
		rip_mstr_i.xfer(o, r);
		chk(r, e);
	endtask
	task automatic send(input logic [7:0] b, input logic a);
		xb({b, 1'b1}, {b, a});
	endtask
	task automatic t_addr;
		logic [6:0] adr [4] = '{7'h66, 7'h67, 7'h6e, 7'h6f};
		for (int i = 0; i < 4; i++) begin
			addr_sel <= 2'(i);
			rip_mstr_i.start();
			send({adr[i], 1'b0}, 1'b0);
			send(8'h20 + 8'(i), 1'b0);
			send(8'ha0 + 8'(i), 1'b0);
			chk({1'b0, regs_flat[(32 + i) * 8 +: 8]}, {1'b0, 8'ha0 + 8'(i)});
			rip_mstr_i.start();
			send(i == 3 ? 8'h00 : {adr[(i + 1) % 4], 1'b0}, 1'b1);
			send(8'h20, 1'b1);
			rip_mstr_i.stop();
		end
	endtask
	task automatic t_seq;
		addr_sel <= 2'h0;
		rip_mstr_i.start();
		send(8'hcc, 1'b0);
		send(8'h30, 1'b0);
		send(8'h5a, 1'b0);
		send(8'ha5, 1'b0);
		rip_mstr_i.start();
		send(8'hcc, 1'b0);
		send(8'h30, 1'b0);
		rip_mstr_i.start();
		send(8'hcd, 1'b0);
		xb(9'h1fe, {8'h5a, 1'b0});
		xb(9'h1ff, {8'ha5, 1'b1});
		rip_mstr_i.stop();
	endtask
	task automatic t_hs;
		for (int i = 0; i < 4; i++) begin
			rip_mstr_i.start();
			send(8'h08 | 8'(i * 2), 1'b1);
			rip_mstr_i.qtr = 4;
			rip_mstr_i.start();
			chk({8'h00, hs_mode}, 9'h001);
			send(8'hcc, 1'b0);
			send(8'h40, 1'b0);
			send(8'(i), 1'b0);
			chk({1'b0, regs_flat[64 * 8 +: 8]}, {1'b0, 8'(i)});
			rip_mstr_i.qtr = 10;
			rip_mstr_i.stop();
			chk({8'h00, hs_mode}, 9'h000);
		end
	endtask
	task automatic t_hold;
		rip_mstr_i.start();
		send(8'hcc, 1'b0);
		send(8'h14, 1'b0);
		send(8'h01, 1'b0);
		rip_mstr_i.start();
		send(8'h0a, 1'b1);
		rip_mstr_i.stop();
		chk({7'h00, hs_mode, fast_mode_hold_enable}, 9'h003);
	endtask
	initial begin
		repeat (3) @(posedge sys_clk);
		rst <= 1'b0;
		repeat (4) @(posedge sys_clk);
		chk({7'h00, hs_mode, fast_mode_hold_enable}, 9'h000);
		t_addr();
		t_seq();
		t_hs();
		t_hold();
		end_sim();
	end
endmodule
`default_nettype wire
